// File: logic/pia_top.sv
// Functional notes
// - mode bits 00 select global-bit control, 10 select eight-level control; others prohibited.
// - a source reaches selection only while its enable bit is 1.
// - global mode: maskable requests accepted when global mask bit is 0, blocked when 1.
// - global mode with mask bit 1: only nmi accepted; others stay pending.
// - global mode: highest default-priority request wins, rest stay pending.
// - exception entry starts only after the current instruction completes.
// - global mode entry stacks program counter and condition code register.
// - global mode: after stacking the global mask bit becomes 1.
// - a vector address is generated for the accepted request and fetched.
// - level mode: source priority levels are compared against the 3-bit mask level.
// - level mode: highest level wins, ties go by default order, losers pend.
// - level mode: accept only when level is strictly above the mask level.
// - level mode entry stacks program counter, condition code and extended control.
// - level mode entry clears trace and loads the accepted level into the mask.
// - level mode: an accepted nmi loads mask level 7.
// - priority determination lasts 3 states external, 2 states internal.
// - instruction wait lasts 1 to 19 plus twice fetch states.
// - entry has two internal states: after acceptance and after vector fetch.
// - entry performs two instruction fetches: prefetch and handler prefetch.
// - fetch cost: internal 1, 8-bit 4 or 6+2m, 16-bit 2 or 3+m.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "pia_defines.svh"

module pia_top #(
   parameter logic [`PIA_NSRC-1:0] EXT_LINES = 8'h0F
) (
   input wire logic pclk, // apb clock, 250 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [`PIA_NSRC-1:0] src_req, // source requests
   input wire logic nmi_req, // non-maskable request
   input wire logic insn_done, // cpu: current instruction complete
   output logic entry_busy, // exception entry running
   output logic stack_push, // pulse: one stack word saved
   output logic [1:0] stack_word, // 0 pc, 1 condition codes, 2 extended control
   output logic vector_fetch, // pulse: vector read begins
   output logic [15:0] vector_addr, // vector location
   output logic insn_fetch, // pulse: one instruction fetch done
   output logic entry_done, // pulse: handler may start
   output logic global_mask, // global mask bit
   output logic [2:0] mask_level // current mask level
);

   pia_pkg::pia_regs_t r_q;
   pia_pkg::pia_regs_t r_d;

   // fetch state count per bus kind
   function automatic logic [7:0] fetch_cost(input logic [2:0] bus, input logic [2:0] m);
      logic [7:0] mw;
      mw = {5'h00, m};
      case (pia_pkg::pia_bus_t'(bus))
         pia_pkg::BUS_INT: fetch_cost = 8'h01;
         pia_pkg::BUS_B8S2: fetch_cost = 8'h04;
         pia_pkg::BUS_B8S3: fetch_cost = 8'h06 + {mw[6:0], 1'b0};
         pia_pkg::BUS_B16S2: fetch_cost = 8'h02;
         pia_pkg::BUS_B16S3: fetch_cost = 8'h03 + mw;
         default: fetch_cost = 8'h01;
      endcase
   endfunction

   logic [7:0] si;
   logic [`PIA_NSRC-1:0] req;
   logic found;
   logic [2:0] best;
   logic [2:0] blvl;
   logic acceptable;
   logic wr_en;
   logic rd_en;
   logic [1:0] last_word;
   logic [7:0] vec_num;

   // candidate selection; low index ranks highest by default
   always_comb begin
      si = fetch_cost(r_q.bus, r_q.waits);
      req = r_q.pending & r_q.enable;
      found = 1'b0;
      best = 3'h0;
      blvl = 3'h0;
      for (int i = 0; i < `PIA_NSRC; i++) begin
         if (req[i]) begin
            if (!found) begin
               found = 1'b1;
               best = 3'(i);
               blvl = (r_q.mode == `PIA_MODE_LEVEL) ? r_q.prio[i] : 3'h0;
            end else if (r_q.mode == `PIA_MODE_LEVEL && r_q.prio[i] > blvl) begin
               best = 3'(i);
               blvl = r_q.prio[i];
            end
         end
      end
      // nmi ignores every mask; prohibited modes take no maskable request
      case (r_q.mode)
         `PIA_MODE_GLOBAL: acceptable = r_q.nmi_pend | (found & ~r_q.gmask);
         `PIA_MODE_LEVEL: acceptable = r_q.nmi_pend | (found & (blvl > r_q.mlevel));
         default: acceptable = r_q.nmi_pend;
      endcase
      last_word = (r_q.mode == `PIA_MODE_LEVEL) ? 2'h2 : 2'h1;
      vec_num = r_q.win_nmi ? `PIA_VEC_NMI : `PIA_VEC_BASE + {5'h00, r_q.win_idx};
      wr_en = psel & penable & r_q.apb.pready & pwrite;
      rd_en = psel & penable & ~r_q.apb.pready & ~pwrite;
   end

   // next state: bus slave, capture, sequencer
   always_comb begin
      r_d = r_q;
      r_d.cpu.stack_push = 1'b0;
      r_d.cpu.vector_fetch = 1'b0;
      r_d.cpu.insn_fetch = 1'b0;
      r_d.cpu.done = 1'b0;
      // one wait state on every access keeps timing uniform
      r_d.apb.pready = psel & penable & ~r_q.apb.pready;
      if (psel & penable & ~r_q.apb.pready) begin
         r_d.apb.pslverr = 1'b0;
         r_d.apb.prdata = 32'h0000_0000;
         case (paddr)
            `PIA_OFF_CTRL: r_d.apb.prdata[7:0] = {r_q.waits, r_q.bus, r_q.mode};
            `PIA_OFF_ENABLE: r_d.apb.prdata[`PIA_NSRC-1:0] = r_q.enable;
            `PIA_OFF_PRIO: begin
               for (int i = 0; i < `PIA_NSRC; i++) begin
                  r_d.apb.prdata[4*i +: 3] = r_q.prio[i];
               end
            end
            `PIA_OFF_MASK: begin
               r_d.apb.prdata[`PIA_MASK_GBIT] = r_q.gmask;
               r_d.apb.prdata[`PIA_MASK_LVL_LSB +: 3] = r_q.mlevel;
               r_d.apb.prdata[`PIA_MASK_TRACE] = r_q.trace;
            end
            `PIA_OFF_STATUS: begin
               r_d.apb.prdata[`PIA_NSRC-1:0] = r_q.pending;
               r_d.apb.prdata[`PIA_STAT_NMI] = r_q.nmi_pend;
               r_d.apb.prdata[`PIA_STAT_ST_LSB +: 4] = r_q.st;
               r_d.apb.prdata[`PIA_STAT_BUSY] = r_q.cpu.busy;
            end
            `PIA_OFF_LAST: r_d.apb.prdata[15:0] = {r_q.last_resp, r_q.last_vec};
            default: r_d.apb.pslverr = 1'b1;
         endcase
         if (!rd_en) begin
            r_d.apb.prdata = 32'h0000_0000;
         end
      end else begin
         // answer stands one cycle only, so a stale error never leaks
         r_d.apb.pslverr = 1'b0;
         r_d.apb.prdata = 32'h0000_0000;
      end
      if (wr_en) begin
         case (paddr)
            `PIA_OFF_CTRL: begin
               r_d.mode = pwdata[`PIA_CTRL_MODE_HI:`PIA_CTRL_MODE_LO];
               r_d.bus = pwdata[`PIA_CTRL_BUS_LSB +: 3];
               r_d.waits = pwdata[`PIA_CTRL_WAIT_LSB +: 3];
            end
            `PIA_OFF_ENABLE: r_d.enable = pwdata[`PIA_NSRC-1:0];
            `PIA_OFF_PRIO: begin
               for (int i = 0; i < `PIA_NSRC; i++) begin
                  r_d.prio[i] = pwdata[4*i +: 3];
               end
            end
            `PIA_OFF_MASK: begin
               r_d.gmask = pwdata[`PIA_MASK_GBIT];
               r_d.mlevel = pwdata[`PIA_MASK_LVL_LSB +: 3];
               r_d.trace = pwdata[`PIA_MASK_TRACE];
            end
            default: ;
         endcase
      end
      // response time counter, saturating
      if (r_q.st != pia_pkg::ST_IDLE && r_q.resp != 8'hFF) begin
         r_d.resp = r_q.resp + 8'h01;
      end
      case (r_q.st)
         pia_pkg::ST_IDLE: begin
            if (acceptable) begin
               r_d.st = pia_pkg::ST_PRIO;
               r_d.win_nmi = r_q.nmi_pend;
               r_d.win_idx = best;
               r_d.win_lvl = blvl;
               r_d.win_ext = r_q.nmi_pend | EXT_LINES[best];
               r_d.cnt = (r_q.nmi_pend | EXT_LINES[best]) ? `PIA_PRIO_EXT : `PIA_PRIO_INT;
               r_d.resp = 8'h01;
               r_d.cpu.busy = 1'b1;
            end
         end
         pia_pkg::ST_PRIO: begin
            r_d.cnt = r_q.cnt - 8'h01;
            if (r_q.cnt == 8'h01) begin
               r_d.st = pia_pkg::ST_WAIT;
               // accepted one leaves pending; losers stay
               if (r_q.win_nmi) begin
                  r_d.nmi_pend = 1'b0;
               end else begin
                  r_d.pending[r_q.win_idx] = 1'b0;
               end
            end
         end
         pia_pkg::ST_WAIT: begin
            // length set by the cpu, 1 to 19+2*si states
            if (insn_done) begin
               r_d.st = pia_pkg::ST_ACPT;
               r_d.cnt = `PIA_INTERNAL;
            end
         end
         pia_pkg::ST_ACPT: begin
            r_d.st = pia_pkg::ST_STACK;
            r_d.cnt = si;
            r_d.word = 2'h0;
         end
         pia_pkg::ST_STACK: begin
            r_d.cnt = r_q.cnt - 8'h01;
            if (r_q.cnt == 8'h01) begin
               r_d.cpu.stack_push = 1'b1;
               r_d.cpu.stack_word = r_q.word;
               r_d.word = r_q.word + 2'h1;
               r_d.cnt = si;
               if (r_q.word == last_word) begin
                  r_d.st = pia_pkg::ST_VECT;
                  r_d.cnt = {si[6:0], 1'b0};
                  r_d.cpu.vector_fetch = 1'b1;
                  r_d.cpu.vector_addr = {6'h00, vec_num, 2'b00};
                  if (r_q.mode == `PIA_MODE_LEVEL) begin
                     r_d.trace = 1'b0;
                     r_d.mlevel = r_q.win_nmi ? `PIA_LVL_MAX : r_q.win_lvl;
                  end else begin
                     r_d.gmask = 1'b1;
                  end
               end
            end
         end
         pia_pkg::ST_VECT: begin
            r_d.cnt = r_q.cnt - 8'h01;
            if (r_q.cnt == 8'h01) begin
               r_d.st = pia_pkg::ST_POST;
               r_d.cnt = `PIA_INTERNAL;
            end
         end
         pia_pkg::ST_POST: begin
            r_d.st = pia_pkg::ST_FETCH;
            r_d.cnt = si;
            r_d.word = 2'h0;
         end
         pia_pkg::ST_FETCH: begin
            r_d.cnt = r_q.cnt - 8'h01;
            if (r_q.cnt == 8'h01) begin
               r_d.cpu.insn_fetch = 1'b1;
               r_d.word = r_q.word + 2'h1;
               r_d.cnt = si;
               if (r_q.word == 2'h1) begin
                  r_d.st = pia_pkg::ST_IDLE;
                  r_d.cpu.busy = 1'b0;
                  r_d.cpu.done = 1'b1;
                  r_d.last_vec = vec_num;
                  r_d.last_resp = r_d.resp;
               end
            end
         end
         default: r_d.st = pia_pkg::ST_IDLE;
      endcase
      // new arrivals win over the acceptance clear
      r_d.pending = r_d.pending | (src_req & r_q.enable);
      r_d.nmi_pend = r_d.nmi_pend | nmi_req;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '0;
         r_q.gmask <= `PIA_RST_GMASK;
         r_q.mlevel <= `PIA_RST_LEVEL;
         r_q.enable <= `PIA_RST_ENABLE;
         r_q.st <= pia_pkg::ST_IDLE;
      end else begin
         r_q <= r_d;
      end
   end

   assign prdata = r_q.apb.prdata;
   assign pready = r_q.apb.pready;
   assign pslverr = r_q.apb.pslverr;
   assign entry_busy = r_q.cpu.busy;
   assign stack_push = r_q.cpu.stack_push;
   assign stack_word = r_q.cpu.stack_word;
   assign vector_fetch = r_q.cpu.vector_fetch;
   assign vector_addr = r_q.cpu.vector_addr;
   assign insn_fetch = r_q.cpu.insn_fetch;
   assign entry_done = r_q.cpu.done;
   assign global_mask = r_q.gmask;
   assign mask_level = r_q.mlevel;

   // checks on the entry sequence
   sequence s_prio_start;
      r_q.st == pia_pkg::ST_IDLE ##1 r_q.st == pia_pkg::ST_PRIO;
   endsequence

   sequence s_stack_end;
      r_q.st == pia_pkg::ST_STACK ##1 r_q.st == pia_pkg::ST_VECT;
   endsequence

   a_global_block: assert property (@(posedge pclk) disable iff (!presetn)
      (r_q.st == pia_pkg::ST_IDLE && r_q.mode == `PIA_MODE_GLOBAL && r_q.gmask
       && !r_q.nmi_pend) |=> r_q.st == pia_pkg::ST_IDLE)
      else $error("maskable request taken with global mask set");

   a_level_above: assert property (@(posedge pclk) disable iff (!presetn)
      (s_prio_start ##0 (r_q.mode == `PIA_MODE_LEVEL && !r_q.win_nmi))
      |-> r_q.win_lvl > $past(r_q.mlevel))
      else $error("accepted level not above mask level");

   a_prio_ext: assert property (@(posedge pclk) disable iff (!presetn)
      (s_prio_start ##0 r_q.win_ext) |-> (r_q.st == pia_pkg::ST_PRIO)[*3]
      ##1 r_q.st == pia_pkg::ST_WAIT)
      else $error("external priority determination not 3 states");

   a_prio_int: assert property (@(posedge pclk) disable iff (!presetn)
      (s_prio_start ##0 !r_q.win_ext) |-> (r_q.st == pia_pkg::ST_PRIO)[*2]
      ##1 r_q.st == pia_pkg::ST_WAIT)
      else $error("internal priority determination not 2 states");

   a_wait_insn: assert property (@(posedge pclk) disable iff (!presetn)
      (r_q.st == pia_pkg::ST_WAIT && !insn_done) |=> r_q.st == pia_pkg::ST_WAIT)
      else $error("entry left wait before instruction end");

   a_stack_words: assert property (@(posedge pclk) disable iff (!presetn)
      s_stack_end |-> r_q.cpu.stack_push && r_q.cpu.stack_word ==
      ((r_q.mode == `PIA_MODE_LEVEL) ? 2'h2 : 2'h1))
      else $error("wrong last stacked word");

   a_gmask_set: assert property (@(posedge pclk) disable iff (!presetn)
      (s_stack_end ##0 r_q.mode == `PIA_MODE_GLOBAL) |-> r_q.gmask)
      else $error("global mask bit not set after stacking");

   a_nmi_level: assert property (@(posedge pclk) disable iff (!presetn)
      (s_stack_end ##0 (r_q.mode == `PIA_MODE_LEVEL && r_q.win_nmi))
      |-> r_q.mlevel == `PIA_LVL_MAX && !r_q.trace)
      else $error("nmi did not raise mask level to 7");

   a_internal_step: assert property (@(posedge pclk) disable iff (!presetn)
      r_q.st == pia_pkg::ST_ACPT |=> r_q.st == pia_pkg::ST_STACK)
      else $error("internal state after acceptance not one state");

   a_two_fetches: assert property (@(posedge pclk) disable iff (!presetn)
      r_q.cpu.vector_fetch |-> ##[2:200] r_q.cpu.insn_fetch ##[1:50] r_q.cpu.done)
      else $error("vector fetch not followed by instruction fetches");

   // acceptance and masking checks
   a_nmi_first: assert property (@(posedge pclk) disable iff (!presetn)
      (r_q.st == pia_pkg::ST_IDLE && r_q.nmi_pend)
      |=> (r_q.st == pia_pkg::ST_PRIO && r_q.win_nmi))
      else $error("pending nmi not taken first");

   a_level_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (r_q.st == pia_pkg::ST_IDLE && r_q.mode == `PIA_MODE_LEVEL && !r_q.nmi_pend
       && blvl <= r_q.mlevel) |=> r_q.st == pia_pkg::ST_IDLE)
      else $error("request at or below mask level taken");

   a_level_load: assert property (@(posedge pclk) disable iff (!presetn)
      (s_stack_end ##0 (r_q.mode == `PIA_MODE_LEVEL && !r_q.win_nmi))
      |-> r_q.mlevel == r_q.win_lvl && !r_q.trace)
      else $error("mask level not loaded with accepted level");

   a_mode_other: assert property (@(posedge pclk) disable iff (!presetn)
      (r_q.st == pia_pkg::ST_IDLE && r_q.mode[0] && !r_q.nmi_pend)
      |=> r_q.st == pia_pkg::ST_IDLE)
      else $error("maskable request taken in a prohibited mode");

   a_src_enabled: assert property (@(posedge pclk) disable iff (!presetn)
      (s_prio_start ##0 !r_q.win_nmi)
      |-> ($past(r_q.enable) & (8'h01 << r_q.win_idx)) != 8'h00)
      else $error("disabled source selected");

   a_done_fetch: assert property (@(posedge pclk) disable iff (!presetn)
      r_q.cpu.done |-> r_q.cpu.insn_fetch && !r_q.cpu.busy)
      else $error("entry done without its last fetch");

endmodule

// File: logic/pia_defines.svh
`ifndef PIA_DEFINES_SVH
`define PIA_DEFINES_SVH

// source count and register byte offsets
`define PIA_NSRC 8
`define PIA_OFF_CTRL 8'h00
`define PIA_OFF_ENABLE 8'h04
`define PIA_OFF_PRIO 8'h08
`define PIA_OFF_MASK 8'h0C
`define PIA_OFF_STATUS 8'h10
`define PIA_OFF_LAST 8'h14

// control register fields
`define PIA_CTRL_MODE_LO 0
`define PIA_CTRL_MODE_HI 1
`define PIA_CTRL_BUS_LSB 2
`define PIA_CTRL_WAIT_LSB 5
// mask register fields
`define PIA_MASK_GBIT 0
`define PIA_MASK_LVL_LSB 4
`define PIA_MASK_TRACE 7
// status and last register fields
`define PIA_STAT_NMI 8
`define PIA_STAT_ST_LSB 12
`define PIA_STAT_BUSY 16
`define PIA_LAST_RESP_LSB 8

// mode encodings and top mask level
`define PIA_MODE_GLOBAL 2'h0
`define PIA_MODE_LEVEL 2'h2
`define PIA_LVL_MAX 3'h7

// reset values
`define PIA_RST_GMASK 1'b1
`define PIA_RST_LEVEL 3'h7
`define PIA_RST_ENABLE 8'h00

// state counts
`define PIA_PRIO_EXT 8'h03
`define PIA_PRIO_INT 8'h02
`define PIA_INTERNAL 8'h01
`define PIA_WAIT_BASE 8'h13

// vector numbers (arbitrary defaults)
`define PIA_VEC_NMI 8'h07
`define PIA_VEC_BASE 8'h10

`endif

// File: logic/pia_pkg.sv
`include "pia_defines.svh"

package pia_pkg;

   // entry sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_PRIO = 4'h1,
      ST_WAIT = 4'h2,
      ST_ACPT = 4'h3,
      ST_STACK = 4'h4,
      ST_VECT = 4'h5,
      ST_POST = 4'h6,
      ST_FETCH = 4'h7
   } pia_st_t;

   // fetch bus kinds for the state-count function
   typedef enum logic [2:0] {
      BUS_INT = 3'h0,
      BUS_B8S2 = 3'h1,
      BUS_B8S3 = 3'h2,
      BUS_B16S2 = 3'h3,
      BUS_B16S3 = 3'h4
   } pia_bus_t;

   // apb answer group
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pia_apb_t;

   // cpu entry group
   typedef struct packed {
      logic busy;
      logic stack_push;
      logic [1:0] stack_word;
      logic vector_fetch;
      logic [15:0] vector_addr;
      logic insn_fetch;
      logic done;
   } pia_cpu_t;

   // whole block state
   typedef struct packed {
      logic [1:0] mode;
      logic [2:0] bus;
      logic [2:0] waits;
      logic [`PIA_NSRC-1:0] enable;
      logic [`PIA_NSRC-1:0][2:0] prio;
      logic gmask;
      logic [2:0] mlevel;
      logic trace;
      logic [`PIA_NSRC-1:0] pending;
      logic nmi_pend;
      pia_st_t st;
      logic [7:0] cnt;
      logic [1:0] word;
      logic [2:0] win_idx;
      logic win_nmi;
      logic win_ext;
      logic [2:0] win_lvl;
      logic [7:0] resp;
      logic [7:0] last_vec;
      logic [7:0] last_resp;
      pia_apb_t apb;
      pia_cpu_t cpu;
   } pia_regs_t;

endpackage

// File: tb/pia_cpu_model.sv
`timescale 1ns/10ps

// cpu core stand-in: ends its current instruction a set number of cycles into entry
module pia_cpu_model (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic entry_busy, // entry running
   input wire logic [7:0] hold, // cycles the current instruction still needs
   output logic insn_done // current instruction complete
);
   logic [7:0] cnt_q;

   // count entry cycles; a long multiply or divide makes hold large
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
      end else if (!entry_busy) begin
         cnt_q <= 8'h00;
      end else if (cnt_q != 8'hff) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // no completion outside entry, so an early start shows up at once
   assign insn_done = entry_busy && (cnt_q >= hold);
endmodule

// File: tb/pia_top_test.sv
`timescale 1ns/10ps
`include "pia_defines.svh"

module pia_top_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [7:0] src_req = 8'h00;
   logic nmi_req = 1'b0;
   logic [7:0] hold = 8'h00;
   logic [31:0] prdata;
   logic pready, pslverr, insn_done, entry_busy, stack_push, vector_fetch;
   logic insn_fetch, entry_done, global_mask;
   logic [1:0] stack_word;
   logic [15:0] vector_addr;
   logic [2:0] mask_level;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int t0, t_done, nw, nf, md, bk, wm;
   integer seed = 32'hd828;
   logic [15:0] va;
   logic early, seen, wbad;
   logic [31:0] r;
   logic e;

   always #2 pclk = ~pclk;

   pia_top pia_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_req(src_req), .nmi_req(nmi_req), .insn_done(insn_done),
      .entry_busy(entry_busy), .stack_push(stack_push), .stack_word(stack_word),
      .vector_fetch(vector_fetch), .vector_addr(vector_addr), .insn_fetch(insn_fetch),
      .entry_done(entry_done), .global_mask(global_mask), .mask_level(mask_level));
   pia_cpu_model pia_cpu_model_i (.pclk(pclk), .presetn(presetn), .entry_busy(entry_busy),
      .hold(hold), .insn_done(insn_done));

   task print_verdict;
      if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // apb master: hold the request until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, x);
   endtask

   task cfg(input int b, input int m, input int mode);
      bk = b;
      wm = m;
      md = mode;
      wr(`PIA_OFF_CTRL, 32'(m * 32 + b * 4 + mode));
   endtask

   // fetch cost per bus kind, m wait states
   function automatic int si(input int b, input int m);
      case (b)
         0: return 1;
         1: return 4;
         2: return 6 + 2 * m;
         3: return 2;
         default: return 3 + m;
      endcase
   endfunction

   // request to entry_done: capture, prio, wait, 2 internal, stack, vector, 2 fetches
   function automatic int lat(input logic ext);
      int s;
      s = si(bk, wm);
      return 2 + (ext ? 3 : 2) + 2 + (md == 2 ? 3 : 2) * s + 2 * s + 1 + 2 * s;
   endfunction

   task clr;
      nw = 0;
      nf = 0;
      early = 1'b0;
      seen = 1'b0;
      wbad = 1'b0;
      va = 16'h0000;
   endtask

   task pulse(input logic [7:0] s, input logic n);
      @(posedge pclk);
      clr();
      src_req <= s;
      nmi_req <= n;
      t0 = cyc;
      @(posedge pclk);
      src_req <= 8'h00;
      nmi_req <= 1'b0;
   endtask

   // wait for one whole entry, then judge what it did
   task wait_entry(input int vec);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (entry_done !== 1'b1 && n < 3000);
      @(negedge pclk);
      chk(nw, md == 2 ? 3 : 2);
      chk(nf, 2);
      chk(va, vec * 4);
      chk(early, 1'b0);
      chk(wbad, 1'b0);
   endtask

   task go(input logic [7:0] s, input logic n, input int vec, input logic ext);
      pulse(s, n);
      wait_entry(vec);
      if (hold == 8'h00) chk(t_done - t0 - 1, lat(ext));
   endtask

   task no_entry(input int n);
      logic b;
      b = 1'b0;
      repeat (n) begin
         @(posedge pclk);
         if (entry_busy !== 1'b0) b = 1'b1;
      end
      chk(b, 1'b0);
   endtask

   // watch the entry outputs; also cut a hang short
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (stack_push === 1'b1) begin
         if (!seen) early = 1'b1;
         if (stack_word !== 2'(nw)) wbad = 1'b1;
         nw++;
      end
      if (entry_busy === 1'b1 && insn_done === 1'b1) seen = 1'b1;
      if (vector_fetch === 1'b1) va = vector_addr;
      if (insn_fetch === 1'b1) nf++;
      if (entry_done === 1'b1) t_done = cyc;
      if (cyc == 30000) begin
         num_errors++;
         print_verdict();
      end
   end

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(global_mask, 1'b1);
      chk(mask_level, 3'h7);
      apb(1'b0, 8'h20, 32'h0000_0000);
      chk(e, 1'b1);
      rd(`PIA_OFF_ENABLE, 32'h0000_0000);
      wr(`PIA_OFF_ENABLE, 32'h0000_00ff);
      wr(`PIA_OFF_MASK, 32'h0000_0000);
      // every fetch bus kind, random wait states
      for (int b = 0; b < 5; b++) begin
         cfg(b, $random(seed) & 7, 0);
         go(8'h20, 1'b0, 21, 1'b0);
         chk(global_mask, 1'b1);
         wr(`PIA_OFF_MASK, 32'h0000_0000);
      end
      go(8'h02, 1'b0, 17, 1'b1);
      wr(`PIA_OFF_MASK, 32'h0000_0000);
      go(8'h48, 1'b0, 19, 1'b1);
      no_entry(30);
      clr();
      wr(`PIA_OFF_MASK, 32'h0000_0000);
      wait_entry(22);
      pulse(8'h04, 1'b0);
      no_entry(40);
      go(8'h00, 1'b1, 7, 1'b1);
      clr();
      wr(`PIA_OFF_MASK, 32'h0000_0000);
      wait_entry(18);
      // mask open, so only the enable bit can keep the source out
      wr(`PIA_OFF_MASK, 32'h0000_0000);
      wr(`PIA_OFF_ENABLE, 32'h0000_00fe);
      pulse(8'h01, 1'b0);
      no_entry(30);
      wr(`PIA_OFF_ENABLE, 32'h0000_00ff);
      no_entry(30);
      hold <= 8'(4 + ($random(seed) & 15));
      go(8'h10, 1'b0, 20, 1'b0);
      hold <= 8'h00;
      // prohibited mode: maskable held, nmi still taken
      cfg(0, 0, 1);
      wr(`PIA_OFF_MASK, 32'h0000_0000);
      pulse(8'h80, 1'b0);
      no_entry(30);
      go(8'h00, 1'b1, 7, 1'b1);
      // level mode
      cfg(0, 0, 2);
      wr(`PIA_OFF_PRIO, 32'h0000_4000);
      wr(`PIA_OFF_MASK, 32'h0000_00c0);
      pulse(8'h08, 1'b0);
      no_entry(30);
      clr();
      wr(`PIA_OFF_PRIO, 32'h0000_5000);
      wait_entry(19);
      chk(mask_level, 3'h5);
      rd(`PIA_OFF_MASK, 32'h0000_0050);
      wr(`PIA_OFF_PRIO, 32'h0700_0660);
      wr(`PIA_OFF_MASK, 32'h0000_0000);
      go(8'h46, 1'b0, 22, 1'b0);
      chk(mask_level, 3'h7);
      clr();
      wr(`PIA_OFF_MASK, 32'h0000_0000);
      wait_entry(17);
      chk(mask_level, 3'h6);
      clr();
      wr(`PIA_OFF_MASK, 32'h0000_0000);
      wait_entry(18);
      chk(mask_level, 3'h6);
      wr(`PIA_OFF_MASK, 32'h0000_0070);
      go(8'h00, 1'b1, 7, 1'b1);
      chk(mask_level, 3'h7);
      rd(`PIA_OFF_LAST, 32'((lat(1'b1) - 1) * 256 + 7));
      print_verdict();
   end
endmodule
